// [hw/cpa_pkg.sv]
package cpa_pkg;
  // ==========================================================
  // timing
  localparam int XTAL_DIV = 6;
  localparam int GROUP_BITS = 104;
  localparam logic [6:0] TB_LAST = 7'h0067;
  localparam logic [6:0] TB_SYNC_BITS = 7'h0002;
  localparam logic [6:0] TB_ADDR_FIRST = 7'h0002;
  localparam logic [6:0] TB_ADDR_PAR = 7'h0012;
  localparam logic [4:0] POS_LAST = 5'h0010;
  localparam logic [4:0] POS_MSB = 5'h000F;
  // ==========================================================
  // poll sequencing
  localparam int POLL_BITS = 11;
  localparam int ADDR_BITS = 10;
  localparam int WORD_BITS = 16;
  localparam int TABLE_WORDS = 16;
  localparam int PARTNER_BIT = 4;
  localparam int PASS_BIT = 5;
  localparam logic [3:0] PTR_LAST = 4'h000F;
  localparam int FIFO_DEPTH = 40;
  // ==========================================================
  // field state counter, one-hot
  typedef enum logic [11:0] {
    FS_1 = 12'h0001, FS_2 = 12'h0002, FS_3 = 12'h0004,
    FS_4 = 12'h0008, FS_5 = 12'h0010, FS_6 = 12'h0020,
    FS_7 = 12'h0040, FS_8 = 12'h0080, FS_9 = 12'h0100,
    FS_10 = 12'h0200, FS_11 = 12'h0400, FS_12 = 12'h0800
  } cpa_state_type;
endpackage

// [hw/cpa_poll_ctrl.sv]
// Summary of operation
// - crystal reference divided by six gives the bit-rate enable.
// - time base counts bit periods modulo 104, one time group.
// - time base count yields sync, data and parity slot enables.
// - field state counter of 12 states preset to 1 at sync.
// - first data slot of each field after the first, and each parity slot, advance the field state by one.
// - end of count 104 pulses the poll counter forward by one.
// - 11-stage poll counter: low bit picks poll type, upper ten address.
// - low-speed addresses ascend 0 to 1023, then wrap.
// - selected address loads a shift register, shifted out serially.
// - 16-word high-speed table is written by host DMA.
// - 32 high-speed polls per load; second pass flips address bit 4.
// - 4-bit table pointer completion, gated by pass flag, asks DMA reload.
// - table reload by DMA happens once every 64 polls.
// - 17th bit after 16 address bits gives odd parity.
// - bit 15 set in state 3 on low-speed poll captures the address.
// - requests answering a high-speed poll are ignored.
// - captured addresses queue in arrival order, 40 deep, 10 wide.
// - ready flag is high while the queue holds an address.
// - ready clears once the last queued address is removed.
// - each group starts with two sync bits, address, then parity.
`timescale 1ns/100ps
module cpa_poll_ctrl #(
  parameter int FIFO_D = cpa_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // crystal reference, sampled level
  input wire logic xtal_ref,
  // host control
  input wire logic tb_init,
  input wire logic dma_we,
  input wire logic [3:0] dma_addr,
  input wire logic [15:0] dma_data,
  output logic dma_req,
  input wire logic unload,
  output logic req_ready,
  output logic [9:0] req_addr,
  // timing status
  output logic bit_tick,
  output logic group_end,
  output logic [6:0] tb_count,
  output logic [11:0] field_state,
  output logic sync_slot,
  output logic data_slot,
  output logic par_slot,
  output logic poll_type_select,
  // downstream modulator
  output logic tx_data,
  output logic tx_gate,
  // upstream demodulated bits
  input wire logic rx_data
);
  // ==========================================================
  // bit-rate enable
  logic xtal_d_r;
  logic xtal_rise;
  logic bit_en;

  assign xtal_rise = xtal_ref && !xtal_d_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      xtal_d_r <= 1'b0;
    end else begin
      xtal_d_r <= xtal_ref;
    end
  end

  cpa_pulse_div #(
    .N(cpa_pkg::XTAL_DIV)
  ) u_xdiv (
    .clk(clk),
    .rst(rst),
    .en_in(xtal_rise),
    .tick(bit_en)
  );

  // ==========================================================
  // time base and field state
  logic run_r;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [4:0] pos_r;
  logic [4:0] pos_nxt;
  cpa_pkg::cpa_state_type fs_r;
  cpa_pkg::cpa_state_type fs_nxt;
  cpa_pkg::cpa_state_type fs_adv;
  logic step;
  logic end_grp;
  logic in_sync_nxt;
  logic adv_nxt;

  assign step = run_r && bit_en;
  assign end_grp = step && (cnt_r == cpa_pkg::TB_LAST);
  assign cnt_nxt = (cnt_r == cpa_pkg::TB_LAST) ? 7'h0000
                   : cnt_r + 7'h0001;
  assign in_sync_nxt = cnt_nxt < cpa_pkg::TB_SYNC_BITS;
  assign pos_nxt = (in_sync_nxt || cnt_nxt == cpa_pkg::TB_ADDR_FIRST
                    || pos_r == cpa_pkg::POS_LAST) ? 5'h0000
                   : pos_r + 5'h0001;
  // first data bit of every field but the poll field, or its parity bit
  assign adv_nxt = (pos_nxt == cpa_pkg::POS_LAST)
                   || (pos_nxt == 5'h0000 && fs_r != cpa_pkg::FS_1);

  always_comb begin
    case (fs_r)
      cpa_pkg::FS_1: fs_adv = cpa_pkg::FS_2;
      cpa_pkg::FS_2: fs_adv = cpa_pkg::FS_3;
      cpa_pkg::FS_3: fs_adv = cpa_pkg::FS_4;
      cpa_pkg::FS_4: fs_adv = cpa_pkg::FS_5;
      cpa_pkg::FS_5: fs_adv = cpa_pkg::FS_6;
      cpa_pkg::FS_6: fs_adv = cpa_pkg::FS_7;
      cpa_pkg::FS_7: fs_adv = cpa_pkg::FS_8;
      cpa_pkg::FS_8: fs_adv = cpa_pkg::FS_9;
      cpa_pkg::FS_9: fs_adv = cpa_pkg::FS_10;
      cpa_pkg::FS_10: fs_adv = cpa_pkg::FS_11;
      cpa_pkg::FS_11: fs_adv = cpa_pkg::FS_12;
      cpa_pkg::FS_12: fs_adv = cpa_pkg::FS_12;
      default: fs_adv = cpa_pkg::FS_1;
    endcase
  end

  always_comb begin
    if (in_sync_nxt) begin
      fs_nxt = cpa_pkg::FS_1;
    end else if (adv_nxt) begin
      fs_nxt = fs_adv;
    end else begin
      fs_nxt = fs_r;
    end
  end

  // counting waits for the host start so groups line up with software
  always_ff @(posedge clk) begin
    if (rst) begin
      run_r <= 1'b0;
      cnt_r <= 7'h0000;
      pos_r <= 5'h0000;
      fs_r <= cpa_pkg::FS_1;
    end else if (tb_init) begin
      run_r <= 1'b1;
      cnt_r <= 7'h0000;
      pos_r <= 5'h0000;
      fs_r <= cpa_pkg::FS_1;
    end else if (step) begin
      cnt_r <= cnt_nxt;
      pos_r <= pos_nxt;
      fs_r <= fs_nxt;
    end
  end

  logic in_sync;
  assign in_sync = cnt_r < cpa_pkg::TB_SYNC_BITS;
  assign sync_slot = run_r && in_sync;
  assign par_slot = run_r && !in_sync && pos_r == cpa_pkg::POS_LAST;
  assign data_slot = run_r && !in_sync && pos_r != cpa_pkg::POS_LAST;
  assign bit_tick = step;
  assign group_end = end_grp;
  assign tb_count = cnt_r;
  assign field_state = fs_r;

  // ==========================================================
  // poll counter and high-speed table
  logic [10:0] poll_r;
  logic [3:0] ptr_r;
  logic [15:0] tbl_r [cpa_pkg::TABLE_WORDS];
  logic [15:0] hs_word;
  logic [15:0] ls_word;
  logic [15:0] sel_word;
  logic is_hs;
  logic pass2;
  logic dma_req_r;

  assign is_hs = poll_r[0];
  assign pass2 = poll_r[cpa_pkg::PASS_BIT];
  assign ls_word = {6'h00, poll_r[10:1]};
  // partner differs in bit 4; the flip adds 16 only to table values with bit 4 clear
  assign hs_word = tbl_r[ptr_r]
                   ^ (16'(pass2) << cpa_pkg::PARTNER_BIT);
  assign sel_word = is_hs ? hs_word : ls_word;
  assign poll_type_select = is_hs;
  assign dma_req = dma_req_r;

  always_ff @(posedge clk) begin
    if (dma_we) begin
      tbl_r[dma_addr] <= dma_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || tb_init) begin
      poll_r <= 11'h0000;
      ptr_r <= 4'h0000;
      dma_req_r <= 1'b0;
    end else begin
      dma_req_r <= end_grp && is_hs && pass2
                   && ptr_r == cpa_pkg::PTR_LAST;
      if (end_grp) begin
        poll_r <= poll_r + 11'h0001;
        if (is_hs) begin
          ptr_r <= ptr_r + 4'h0001;
        end
      end
    end
  end

  // ==========================================================
  // downstream serialiser with odd parity
  logic [15:0] sr_r;
  logic par_r;
  logic tx_r;
  logic gate_r;
  logic ld_now;
  logic sh_now;
  logic par_now;

  assign ld_now = cnt_nxt == cpa_pkg::TB_ADDR_FIRST;
  assign sh_now = cnt_nxt > cpa_pkg::TB_ADDR_FIRST
                  && cnt_nxt < cpa_pkg::TB_ADDR_PAR;
  assign par_now = cnt_nxt == cpa_pkg::TB_ADDR_PAR;
  assign tx_data = tx_r;
  assign tx_gate = gate_r;

  always_ff @(posedge clk) begin
    if (rst || tb_init) begin
      sr_r <= 16'h0000;
      par_r <= 1'b0;
      tx_r <= 1'b0;
      gate_r <= 1'b0;
    end else if (step) begin
      gate_r <= cnt_nxt <= cpa_pkg::TB_ADDR_PAR;
      if (in_sync_nxt) begin
        tx_r <= 1'b1;
      end else if (ld_now) begin
        tx_r <= sel_word[0];
        sr_r <= sel_word >> 1;
        par_r <= sel_word[0];
      end else if (sh_now) begin
        tx_r <= sr_r[0];
        sr_r <= sr_r >> 1;
        par_r <= par_r ^ sr_r[0];
      end else if (par_now) begin
        tx_r <= !par_r;
      end else begin
        tx_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // request for high-speed service
  logic [15:0] rq_sr_r;
  logic rq_push;

  // ignoring answers to high-speed polls keeps polls apart in time
  assign rq_push = step && fs_r == cpa_pkg::FS_3
                   && pos_r == cpa_pkg::POS_MSB && rx_data
                   && !is_hs;

  always_ff @(posedge clk) begin
    if (rst) begin
      rq_sr_r <= 16'h0000;
    end else if (step && fs_r == cpa_pkg::FS_1 && data_slot) begin
      rq_sr_r <= {rx_data, rq_sr_r[15:1]};
    end
  end

  cpa_req_fifo #(
    .W(cpa_pkg::ADDR_BITS),
    .D(FIFO_D)
  ) u_rq (
    .clk(clk),
    .rst(rst),
    .push(rq_push),
    .wdata(rq_sr_r[9:0]),
    .full(),
    .pop(unload),
    .rdata(req_addr),
    .not_empty(req_ready)
  );
endmodule // cpa_poll_ctrl

// [hw/cpa_pulse_div.sv]
`timescale 1ns/100ps
module cpa_pulse_div #(
  parameter int N = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pulses in and out
  input wire logic en_in,
  output logic tick
);
  localparam int CW = (N > 1) ? $clog2(N) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(N - 1);

  logic [CW-1:0] cnt_r;
  logic wrap;

  assign wrap = en_in && (cnt_r == CNT_LAST);
  assign tick = wrap;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (wrap) begin
      cnt_r <= '0;
    end else if (en_in) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end
endmodule // cpa_pulse_div

// [hw/cpa_req_fifo.sv]
`timescale 1ns/100ps
module cpa_req_fifo #(
  parameter int W = 10,
  parameter int D = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side
  input wire logic push,
  input wire logic [W-1:0] wdata,
  output logic full,
  // read side
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic not_empty
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(D - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);

  logic [W-1:0] mem_r [D];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [CW-1:0] cnt_r;
  logic do_push;
  logic do_pop;

  assign full = (cnt_r == CNT_FULL);
  assign not_empty = (cnt_r != '0);
  assign do_pop = pop && not_empty;
  // when full a new entry is dropped unless a pop frees a slot in the same cycle; stored ones stay intact
  assign do_push = push && (!full || do_pop);
  assign rdata = mem_r[rd_r];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_r[wr_r] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) begin
        wr_r <= (wr_r == PTR_LAST) ? '0 : wr_r + PW'(1);
      end
      if (do_pop) begin
        rd_r <= (rd_r == PTR_LAST) ? '0 : rd_r + PW'(1);
      end
      if (do_push && !do_pop) begin
        cnt_r <= cnt_r + CW'(1);
      end else if (do_pop && !do_push) begin
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end
endmodule // cpa_req_fifo

// [test/cpa_poll_chk.sv]
`timescale 1ns/100ps
module cpa_poll_chk #(
  parameter int FIFO_D = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host side
  input wire logic tb_init,
  input wire logic dma_req,
  input wire logic req_ready,
  // timing status
  input wire logic bit_tick,
  input wire logic group_end,
  input wire logic [6:0] tb_count,
  input wire logic [11:0] field_state,
  input wire logic sync_slot,
  input wire logic data_slot,
  input wire logic par_slot,
  input wire logic poll_type_select,
  // line
  input wire logic tx_data,
  input wire logic tx_gate
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // helpers
  logic run;
  logic is_par;
  logic par_acc_r;
  logic par_acc_nxt;
  assign run = bit_tick && !tb_init;
  assign is_par = (tb_count >= 7'h12) && ((tb_count - 7'h12) % 7'h11 == 7'h00);
  // cleared at bit 1 so a restart mid-group cannot leave stale parity
  assign par_acc_nxt = (tb_count == 7'h01) ? 1'b0 : (par_acc_r ^ tx_data);
  always_ff @(posedge clk) begin
    if (rst) begin
      par_acc_r <= 1'b0;
    end else if (bit_tick) begin
      par_acc_r <= par_acc_nxt;
    end
  end
  // ==========================================================
  // properties
  sequence s_sync; tx_gate && tx_data; endsequence
  sequence s_quiet; !tx_gate && !tx_data; endsequence
  property p_div; bit_tick |=> !bit_tick [*8]; endproperty
  property p_count;
    run && tb_count != 7'h67 |=> tb_count == $past(tb_count) + 7'h01;
  endproperty
  property p_wrap; run && tb_count == 7'h67 |-> group_end ##1 tb_count == 7'h00;
  endproperty
  property p_slots;
    bit_tick |-> sync_slot == (tb_count < 7'h02) && par_slot == is_par
      && data_slot == !(tb_count < 7'h02 || is_par);
  endproperty
  property p_preset; tb_count <= 7'h01 |-> field_state == cpa_pkg::FS_1;
  endproperty
  property p_step; run && tb_count == 7'h11 |=> field_state == cpa_pkg::FS_2;
  endproperty
  property p_last; tb_count == 7'h67 |-> field_state == cpa_pkg::FS_12;
  endproperty
  property p_tx; run && tb_count == 7'h00 |=> s_sync; endproperty
  property p_gate; run && tb_count == 7'h12 |=> s_quiet; endproperty
  property p_par; bit_tick && tb_count == 7'h12 |-> tx_data == !par_acc_r;
  endproperty
  property p_type;
    group_end && !tb_init |=> poll_type_select != $past(poll_type_select);
  endproperty
  property p_req;
    $rose(req_ready) |-> !poll_type_select && tb_count == 7'h23;
  endproperty
  property p_dma; dma_req |-> $past(group_end) && !poll_type_select ##1 !dma_req;
  endproperty
  a_div: assert property (p_div) else $error("bit tick early");
  a_count: assert property (p_count) else $error("count step");
  a_wrap: assert property (p_wrap) else $error("group wrap");
  a_slots: assert property (p_slots) else $error("slot decode");
  a_preset: assert property (p_preset) else $error("no preset");
  a_step: assert property (p_step) else $error("state step");
  a_last: assert property (p_last) else $error("last state");
  a_tx: assert property (p_tx) else $error("sync bits");
  a_gate: assert property (p_gate) else $error("gate close");
  a_par: assert property (p_par) else $error("parity bit");
  a_type: assert property (p_type) else $error("poll type");
  a_req: assert property (p_req) else $error("bad capture");
  a_dma: assert property (p_dma) else $error("reload pulse");
endmodule // cpa_poll_chk

bind cpa_poll_ctrl cpa_poll_chk #(.FIFO_D(FIFO_D)) u_chk (.*);

// [test/cpa_poll_ctrl_tb.sv]
`timescale 1ns/100ps
module cpa_poll_ctrl_tb;
  // ==========================================================
  // signals
  logic clk, rst, xtal_ref, tb_init, dma_we, unload, req_on, rx_data;
  logic [3:0] dma_addr;
  logic [15:0] dma_data, w, exp;
  logic p, dma_req, req_ready, bit_tick, group_end, sync_slot, data_slot;
  logic par_slot, poll_type_select, tx_data, tx_gate;
  logic [9:0] req_addr;
  logic [6:0] tb_count;
  logic [11:0] field_state;
  logic [15:0] tbl [16];
  int failures = 0, samples_checked = 0, dma_seen = 0;
  cpa_poll_ctrl #(.FIFO_D(4)) dut (.clk(clk), .rst(rst), .xtal_ref(xtal_ref),
    .tb_init(tb_init), .dma_we(dma_we), .dma_addr(dma_addr),
    .dma_data(dma_data), .dma_req(dma_req), .unload(unload),
    .req_ready(req_ready), .req_addr(req_addr), .bit_tick(bit_tick),
    .group_end(group_end), .tb_count(tb_count), .field_state(field_state),
    .sync_slot(sync_slot), .data_slot(data_slot), .par_slot(par_slot),
    .poll_type_select(poll_type_select), .tx_data(tx_data),
    .tx_gate(tx_gate), .rx_data(rx_data));
  cpa_term_model term (.tb_count(tb_count), .tx_data(tx_data),
    .req_on(req_on), .rx_data(rx_data));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // reference toggled every falling edge keeps the run short
  always @(negedge clk) xtal_ref <= ~xtal_ref;
  always @(posedge clk) if (dma_req === 1'b1) dma_seen++;
  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wait_idx(input logic [6:0] k);
    int n;
    n = 0;
    while (tb_count !== k && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) failures++;
  endtask
  task automatic rd_group(output logic [15:0] wd, output logic pb);
    wait_idx(7'h01);
    chk({14'h0000, tx_gate, tx_data}, 16'h0003);
    for (int i = 0; i < 16; i++) begin
      wait_idx(7'(i + 2));
      wd[i] = tx_data;
    end
    wait_idx(7'h12);
    pb = tx_data;
    wait_idx(7'h13);
    chk({14'h0000, tx_gate, tx_data}, 16'h0000);
  endtask
  task automatic wr_table(input logic [15:0] base);
    for (int i = 0; i < 16; i++) begin
      tbl[i] = base + 16'(i * 37);
      dma_we = 1'b1;
      dma_addr = 4'(i);
      dma_data = tbl[i];
      @(negedge clk);
    end
    dma_we = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    // 66 groups of 1248 cycles fit well inside this span
    #1900000;
    failures++;
    report_and_stop();
  end
  initial begin
    xtal_ref = 1'b0;
    rst = 1'b1;
    tb_init = 1'b0;
    dma_we = 1'b0;
    dma_addr = 4'h0;
    dma_data = 16'h0000;
    unload = 1'b0;
    req_on = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk({15'h0000, req_ready}, 16'h0000);
    chk({4'h0, field_state}, {4'h0, cpa_pkg::FS_1});
    wr_table(16'h0105);
    tb_init = 1'b1;
    @(negedge clk);
    tb_init = 1'b0;
    req_on = 1'b1;
    $display("test reset done");
    for (int g = 0; g < 66; g++) begin
      rd_group(w, p);
      exp = g[0] ? (tbl[((g - 1) / 2) % 16] ^ {11'h000, g[5], 4'h0})
        : {6'h00, 10'(g / 2)};
      chk(w, exp);
      chk({15'h0000, p}, {15'h0000, ~^exp});
      if (g == 63) begin
        for (int n = 0; n < 3000 && dma_req !== 1'b1; n++) @(negedge clk);
        // the pulse is counted at the next rising edge
        @(negedge clk);
        chk(16'(dma_seen), 16'h0001);
        wr_table(16'h0207);
      end
    end
    req_on = 1'b0;
    $display("test polls done");
    // low polls 0..3 fill the shrunken queue; later ones are dropped
    for (int k = 0; k < 4; k++) begin
      chk({15'h0000, req_ready}, 16'h0001);
      chk({6'h00, req_addr}, 16'(k));
      unload = 1'b1;
      @(negedge clk);
      unload = 1'b0;
      @(negedge clk);
    end
    chk({15'h0000, req_ready}, 16'h0000);
    $display("test queue done");
    report_and_stop();
  end
endmodule // cpa_poll_ctrl_tb

// [test/cpa_term_model.sv]
`timescale 1ns/100ps
module cpa_term_model (
  // controller timing
  input wire logic [6:0] tb_count,
  // downstream poll
  input wire logic tx_data,
  // bench control
  input wire logic req_on,
  // upstream reply
  output logic rx_data
);
  // ==========================================================
  // reply shaping
  logic in_addr;
  logic at_req;
  // polled terminal answers with its own address in field one
  assign in_addr = (tb_count >= 7'h02) && (tb_count <= 7'h11);
  assign at_req = (tb_count == 7'h22);
  // other slots toggle so a stale bit never looks like data
  assign rx_data = in_addr ? tx_data : (at_req ? req_on : tb_count[0]);
endmodule // cpa_term_model
